// ===== src/wbm_slice.v
// execution slice: word block moves, mode test, multiply, negate, byte or
`timescale 1ns/1ps
`include "wbm_defines.vh"
// Summary of operation
// RULE1: move down copies word, pointers drop
// RULE2: move up copies word, pointers rise
// RULE3: counter low half drops by bytes
// RULE4: single move: V=count nonzero, H,N clear
// RULE5: software keeps pointers and count even
// RULE6: repeat down until zero; zero means 65536
// RULE7: down walk keeps overlapping low source
// RULE8: up walk keeps overlapping high source
// RULE9: repeats yield to interrupt, restart pc
// RULE10: mode test copies bits 7,6,1
// RULE11: multiply low halves into 32 bits
// RULE12: multiply flags: C big, Z zero
// RULE13: negate low half, 8000 sets V
// RULE14: negate flags S Z H N, C nonzero
// RULE15: or accumulator with source
// RULE16: or flags S Z P, clear H N C
// RULE17: index byte select 0 high, 1 low
// RULE18: long mode sampled per basic move
module wbm_slice #(
	parameter MUL_CYCLES = `WBM_MUL_CYCLES,
	parameter FIFO_DEPTH = 8
)
(
	// clock and reset
	input wire clk_sys_i,
	input wire nrst_i,
	// instruction request
	input wire start_i,
	input wire [3:0] op_i,
	input wire [31:0] instr_pc_i,
	output wire busy_o,
	output reg done_o,
	// mode and interrupt
	input wire long_word_mode_i,
	input wire [7:0] select_register_i,
	input wire irq_pending_i,
	output reg irq_take_o,
	output reg [31:0] resume_pc_o,
	// operands
	input wire [15:0] src_operand_i,
	input wire [7:0] or_src_i,
	input wire or_src_is_index_i,
	input wire or_byte_sel_i,
	input wire [15:0] index_register_i,
	// register file in
	input wire [31:0] source_pointer_register_i,
	input wire [31:0] destination_pointer_register_i,
	input wire [31:0] count_register_i,
	input wire [7:0] acc_i,
	input wire [7:0] flags_i,
	// register file out
	output reg [31:0] source_pointer_register_o,
	output reg [31:0] destination_pointer_register_o,
	output reg [31:0] count_register_o,
	output reg [7:0] acc_o,
	output reg [7:0] flags_o,
	// memory read port
	output reg rd_req_o,
	output reg [31:0] rd_addr_o,
	output reg rd_long_o,
	input wire rd_ack_i,
	input wire [31:0] rd_data_i,
	// memory write port
	output wire wr_req_o,
	output wire [31:0] wr_addr_o,
	output wire [31:0] wr_data_o,
	output wire wr_long_o,
	input wire wr_ack_i
);
	// ----------------------------------------
	// states
	// ----------------------------------------
	localparam ST_IDLE = 3'h0;
	localparam ST_READ = 3'h1;
	localparam ST_WAIT = 3'h2;
	localparam ST_DRAIN = 3'h3;
	localparam ST_MUL = 3'h4;
	localparam [3:0] MUL_LAST = MUL_CYCLES[3:0] - 4'h1; // fixed latency less one; the counter stops one below this
	reg [2:0] st_q; // machine state
	reg [3:0] op_q; // latched operation
	reg long_q; // width of current basic move
	reg [3:0] mul_cnt_q; // multiply cycle counter
	reg [15:0] mul_src_q; // held multiplier
	reg more_q; // counter still nonzero
	wire fifo_in_ready; // fifo has room
	wire fifo_out_valid; // word waiting to be written
	wire [64:0] fifo_out; // address, data, width
	wire [15:0] step; // bytes per move
	wire [15:0] cnt_next; // decremented count
	wire is_move; // op is a block move
	wire is_rep; // op repeats
	wire is_down; // pointers descend
	wire [15:0] neg_res; // negate result
	wire [31:0] prod; // multiply product
	wire [7:0] or_opnd; // chosen or operand
	wire [7:0] or_res; // or result
	assign is_move = (op_q >= `WBM_OP_MOVE_DOWN) && (op_q <= `WBM_OP_MOVE_UP_REP);
	assign is_rep = (op_q == `WBM_OP_MOVE_DOWN_REP) || (op_q == `WBM_OP_MOVE_UP_REP);
	assign is_down = (op_q == `WBM_OP_MOVE_DOWN) || (op_q == `WBM_OP_MOVE_DOWN_REP);
	assign step = long_q ? `WBM_BYTES_LONG : `WBM_BYTES_WORD;
	assign cnt_next = count_register_o[15:0] - step; // RULE3
	assign busy_o = (st_q != ST_IDLE);
	assign neg_res = 16'h0000 - source_pointer_register_i[15:0]; // RULE13
	assign prod = source_pointer_register_o[15:0] * mul_src_q; // RULE11
	assign or_opnd = or_src_is_index_i ?
		(or_byte_sel_i ? index_register_i[7:0] : index_register_i[15:8]) : or_src_i; // RULE17
	assign or_res = acc_i | or_opnd; // RULE15
	// ----------------------------------------
	// write buffer between memory read and write
	// ----------------------------------------
	wbm_fifo #(.WIDTH(65), .DEPTH(FIFO_DEPTH), .AW(3)) u_fifo (
		.clk_sys_i(clk_sys_i),
		.nrst_i(nrst_i),
		.in_valid_i(rd_req_o && rd_ack_i),
		.in_ready_o(fifo_in_ready),
		.in_data_i({long_q, destination_pointer_register_o, rd_data_i}),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(wr_ack_i),
		.out_data_o(fifo_out)
	);
	assign wr_req_o = fifo_out_valid;
	assign wr_long_o = fifo_out[64];
	assign wr_addr_o = fifo_out[63:32];
	// width travels with the word, so a later mode change cannot reshape it
	assign wr_data_o = fifo_out[64] ? fifo_out[31:0] : {16'h0000, fifo_out[15:0]};
	// ----------------------------------------
	// main sequencer
	// ----------------------------------------
	always @(posedge clk_sys_i)
	begin
		if (!nrst_i)
		begin
			st_q <= ST_IDLE;
			op_q <= `WBM_OP_NONE;
			long_q <= 1'b0;
			mul_cnt_q <= 4'h0;
			mul_src_q <= 16'h0000;
			more_q <= 1'b0;
			done_o <= 1'b0;
			irq_take_o <= 1'b0;
			resume_pc_o <= 32'h0000_0000;
			source_pointer_register_o <= 32'h0000_0000;
			destination_pointer_register_o <= 32'h0000_0000;
			count_register_o <= 32'h0000_0000;
			acc_o <= 8'h00;
			flags_o <= 8'h00;
			rd_req_o <= 1'b0;
			rd_addr_o <= 32'h0000_0000;
			rd_long_o <= 1'b0;
		end
		else
		begin
			done_o <= 1'b0;
			irq_take_o <= 1'b0;
			case (st_q)
				ST_IDLE:
				begin
					if (start_i)
					begin
						op_q <= op_i;
						resume_pc_o <= instr_pc_i; // RULE9
						source_pointer_register_o <= source_pointer_register_i;
						destination_pointer_register_o <= destination_pointer_register_i;
						count_register_o <= count_register_i;
						acc_o <= acc_i;
						flags_o <= flags_i;
						case (op_i)
							`WBM_OP_MOVE_DOWN, `WBM_OP_MOVE_UP,
							`WBM_OP_MOVE_DOWN_REP, `WBM_OP_MOVE_UP_REP:
								st_q <= ST_READ;
							`WBM_OP_MODE_TEST:
							begin
								// mode bits straight into flags
								flags_o[`WBM_FLG_S] <= select_register_i[`WBM_SEL_S_BIT]; // RULE10
								flags_o[`WBM_FLG_Z] <= select_register_i[`WBM_SEL_Z_BIT]; // RULE10
								flags_o[`WBM_FLG_C] <= select_register_i[`WBM_SEL_C_BIT]; // RULE10
								done_o <= 1'b1;
							end
							`WBM_OP_MULTIPLY:
							begin
								mul_src_q <= src_operand_i;
								mul_cnt_q <= 4'h0;
								st_q <= ST_MUL;
							end
							`WBM_OP_NEGATE:
							begin
								// two's complement; 8000 maps to itself
								source_pointer_register_o[15:0] <= neg_res; // RULE13
								flags_o[`WBM_FLG_S] <= neg_res[15]; // RULE14
								flags_o[`WBM_FLG_Z] <= (neg_res == 16'h0000); // RULE14
								flags_o[`WBM_FLG_H] <= (source_pointer_register_i[3:0] != 4'h0); // RULE14
								flags_o[`WBM_FLG_PV] <=
									(source_pointer_register_i[15:0] == `WBM_NEG_MIN); // RULE13
								flags_o[`WBM_FLG_N] <= 1'b1; // RULE14
								flags_o[`WBM_FLG_C] <= (source_pointer_register_i[15:0] != 16'h0000); // RULE14
								done_o <= 1'b1;
							end
							`WBM_OP_OR:
							begin
								acc_o <= or_res; // RULE15
								flags_o[`WBM_FLG_S] <= or_res[7]; // RULE16
								flags_o[`WBM_FLG_Z] <= (or_res == 8'h00); // RULE16
								flags_o[`WBM_FLG_H] <= 1'b0; // RULE16
								flags_o[`WBM_FLG_PV] <= ~(^or_res); // RULE16
								flags_o[`WBM_FLG_N] <= 1'b0; // RULE16
								flags_o[`WBM_FLG_C] <= 1'b0; // RULE16
								done_o <= 1'b1;
							end
							default:
								done_o <= 1'b1;
						endcase
					end
				end
				ST_READ:
				begin
					// start one basic move; width sampled now
					long_q <= long_word_mode_i; // RULE18
					rd_addr_o <= source_pointer_register_o;
					rd_long_o <= long_word_mode_i;
					rd_req_o <= 1'b1;
					st_q <= ST_WAIT;
				end
				ST_WAIT:
				begin
					// read returns and goes to the buffer; pointers step on the same edge
					if (rd_ack_i && fifo_in_ready)
					begin
						rd_req_o <= 1'b0;
						count_register_o[15:0] <= cnt_next; // RULE3
						more_q <= (cnt_next != 16'h0000);
						if (is_down)
						begin
							source_pointer_register_o <= source_pointer_register_o - {16'h0000, step}; // RULE1 RULE7
							destination_pointer_register_o <=
								destination_pointer_register_o - {16'h0000, step}; // RULE1 RULE7
						end
						else
						begin
							source_pointer_register_o <= source_pointer_register_o + {16'h0000, step}; // RULE2 RULE8
							destination_pointer_register_o <=
								destination_pointer_register_o + {16'h0000, step}; // RULE2 RULE8
						end
						st_q <= ST_DRAIN;
					end
				end
				ST_DRAIN:
				begin
					// wait for the write to land before next move
					if (!fifo_out_valid)
					begin
						flags_o[`WBM_FLG_H] <= 1'b0; // RULE4 RULE6
						flags_o[`WBM_FLG_N] <= 1'b0; // RULE4 RULE6
						if (!is_rep)
						begin
							flags_o[`WBM_FLG_PV] <= more_q; // RULE4
							done_o <= 1'b1;
							st_q <= ST_IDLE;
						end
						else if (!more_q)
						begin
							// zero at start wraps, giving 65536 bytes worth
							flags_o[`WBM_FLG_PV] <= 1'b0; // RULE6
							done_o <= 1'b1;
							st_q <= ST_IDLE;
						end
						else if (irq_pending_i)
						begin
							// yield; caller restarts at resume_pc_o
							irq_take_o <= 1'b1; // RULE9
							st_q <= ST_IDLE;
						end
						else
							st_q <= ST_READ; // RULE6
					end
				end
				ST_MUL:
				begin
					// fixed latency product
					// done lands MUL_CYCLES - 1 edges after the take edge
					if (mul_cnt_q == MUL_LAST - 4'h1) // RULE11
					begin
						source_pointer_register_o <= prod; // RULE11
						flags_o[`WBM_FLG_C] <= (prod >= `WBM_PROD_LIMIT); // RULE12
						flags_o[`WBM_FLG_Z] <= (prod == 32'h0000_0000); // RULE12
						flags_o[`WBM_FLG_S] <= 1'b0; // RULE12
						flags_o[`WBM_FLG_PV] <= 1'b0; // RULE12
						done_o <= 1'b1;
						st_q <= ST_IDLE;
					end
					else
						mul_cnt_q <= mul_cnt_q + 1'b1;
				end
				default:
					st_q <= ST_IDLE;
			endcase
		end
	end
endmodule // wbm_slice

// ===== src/wbm_defines.vh
// constants for the word block-move and alu execution slice
`ifndef WBM_DEFINES_VH
`define WBM_DEFINES_VH
// ----------------------------------------
// operation codes presented on op_i
// ----------------------------------------
`define WBM_OP_NONE 4'h0
`define WBM_OP_MOVE_DOWN 4'h1
`define WBM_OP_MOVE_UP 4'h2
`define WBM_OP_MOVE_DOWN_REP 4'h3
`define WBM_OP_MOVE_UP_REP 4'h4
`define WBM_OP_MODE_TEST 4'h5
`define WBM_OP_MULTIPLY 4'h6
`define WBM_OP_NEGATE 4'h7
`define WBM_OP_OR 4'h8
// ----------------------------------------
// instruction opcodes kept for reference by the decoder
// ----------------------------------------
`define WBM_OPC_MOVE_DOWN 16'hede8
`define WBM_OPC_MOVE_UP 16'hede0
`define WBM_OPC_MOVE_DOWN_REP 16'hedf8
`define WBM_OPC_MOVE_UP_REP 16'hedf0
`define WBM_OPC_MULTIPLY 16'hedcb
// ----------------------------------------
// flag bit positions in the flag byte
// ----------------------------------------
`define WBM_FLG_S 7
`define WBM_FLG_Z 6
`define WBM_FLG_H 4
`define WBM_FLG_PV 2
`define WBM_FLG_N 1
`define WBM_FLG_C 0
// ----------------------------------------
// select register mode bits copied by mode test
// ----------------------------------------
`define WBM_SEL_S_BIT 7
`define WBM_SEL_Z_BIT 6
`define WBM_SEL_C_BIT 1
// ----------------------------------------
// sizes and timing
// ----------------------------------------
`define WBM_BYTES_WORD 16'h0002
`define WBM_BYTES_LONG 16'h0004
`define WBM_NEG_MIN 16'h8000
`define WBM_MUL_CYCLES 11
`define WBM_PROD_LIMIT 32'h0001_0000
`endif

// ===== src/wbm_fifo.v
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module wbm_fifo #(
	parameter WIDTH = 32,
	parameter DEPTH = 8,
	parameter AW = 3
)
(
	// clock and reset
	input wire clk_sys_i,
	input wire nrst_i,
	// fill side
	input wire in_valid_i,
	output wire in_ready_o,
	input wire [WIDTH-1:0] in_data_i,
	// drain side
	output wire out_valid_o,
	input wire out_ready_i,
	output wire [WIDTH-1:0] out_data_o
);
	reg [WIDTH-1:0] mem_q [0:DEPTH-1]; // storage words
	reg [AW-1:0] wr_q; // write pointer
	reg [AW-1:0] rd_q; // read pointer
	reg [AW:0] cnt_q; // fill level
	wire push; // word accepted
	wire pop; // word drained
	assign in_ready_o = (cnt_q != DEPTH[AW:0]);
	assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
	assign out_data_o = mem_q[rd_q];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	// ----------------------------------------
	// pointer and level update
	// ----------------------------------------
	always @(posedge clk_sys_i)
	begin
		if (!nrst_i)
		begin
			wr_q <= {AW{1'b0}};
			rd_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
			begin
				mem_q[wr_q] <= in_data_i;
				wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
			end
			if (pop)
				rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
			if (push && !pop)
				cnt_q <= cnt_q + 1'b1;
			else if (pop && !push)
				cnt_q <= cnt_q - 1'b1;
		end
	end
endmodule // wbm_fifo

// ===== tb/wbm_slice_chk.sv
// port checker for the execution slice, bound onto wbm_slice
`timescale 1ns/1ps
`include "wbm_defines.vh"
module wbm_slice_chk #(parameter MUL_CYCLES = 11, parameter FIFO_DEPTH = 8) (
	// clock, reset, request
	input wire clk_sys_i,
	input wire nrst_i,
	input wire start_i,
	input wire [3:0] op_i,
	input wire [31:0] instr_pc_i,
	input wire busy_o,
	input wire done_o,
	// mode, interrupt, operands
	input wire [7:0] select_register_i,
	input wire irq_take_o,
	input wire [31:0] resume_pc_o,
	input wire [7:0] or_src_i,
	input wire or_src_is_index_i,
	input wire or_byte_sel_i,
	input wire [15:0] index_register_i,
	input wire [31:0] source_pointer_register_i,
	input wire [7:0] acc_i,
	// results
	input wire [31:0] source_pointer_register_o,
	input wire [31:0] count_register_o,
	input wire [7:0] acc_o,
	input wire [7:0] flags_o
);
	reg [3:0] op_q; // op of the running instruction
	reg [31:0] pc_q; // its start pc
	wire tk = start_i && !busy_o; // request taken
	wire [7:0] opnd = !or_src_is_index_i ? or_src_i :
		(or_byte_sel_i ? index_register_i[7:0] : index_register_i[15:8]);
	wire [7:0] or_res = acc_i | opnd;
	wire [15:0] neg_res = 16'h0000 - source_pointer_register_i[15:0];
	wire neg_v = source_pointer_register_i[15:0] == 16'h8000;
	wire neg_c = source_pointer_register_i[15:0] != 16'h0000;
	wire [2:0] mbits = {select_register_i[7], select_register_i[6], select_register_i[1]};
	wire mv1 = op_q == `WBM_OP_MOVE_DOWN || op_q == `WBM_OP_MOVE_UP;
	wire mvr = op_q == `WBM_OP_MOVE_DOWN_REP || op_q == `WBM_OP_MOVE_UP_REP;
	always @(posedge clk_sys_i)
	begin
		if (!nrst_i)
		begin
			op_q <= 4'h0;
			pc_q <= 32'h0;
		end
		else if (tk)
		begin
			op_q <= op_i;
			pc_q <= instr_pc_i;
		end
	end
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);
	AST_MUL_LAT: assert property (tk && op_i == `WBM_OP_MULTIPLY |-> ##3 (!done_o)[*8] ##1 done_o)
		else $error("multiply latency wrong");
	AST_OR_RES: assert property (tk && op_i == `WBM_OP_OR |=> done_o && acc_o == $past(or_res))
		else $error("or result wrong");
	AST_OR_FLG: assert property (done_o && op_q == `WBM_OP_OR |-> flags_o[7] == acc_o[7] && flags_o[6] == (acc_o == 8'h00) && flags_o[2] == ~^acc_o && !flags_o[4] && !flags_o[1] && !flags_o[0])
		else $error("or flags wrong");
	AST_NEG: assert property (tk && op_i == `WBM_OP_NEGATE |=> source_pointer_register_o[15:0] == $past(neg_res) && flags_o[2] == $past(neg_v) && flags_o[0] == $past(neg_c) && flags_o[1])
		else $error("negate wrong");
	AST_MODE: assert property (tk && op_i == `WBM_OP_MODE_TEST |=> {flags_o[7], flags_o[6], flags_o[0]} == $past(mbits))
		else $error("mode flags wrong");
	AST_MUL_FLG: assert property (done_o && op_q == `WBM_OP_MULTIPLY |-> flags_o[0] == (source_pointer_register_o[31:16] != 16'h0) && flags_o[6] == (source_pointer_register_o == 32'h0) && !flags_o[7] && !flags_o[2])
		else $error("multiply flags wrong");
	AST_MOVE_FLG: assert property (done_o && mv1 |-> !flags_o[4] && !flags_o[1] && flags_o[2] == (count_register_o[15:0] != 16'h0))
		else $error("move flags wrong");
	AST_REP_END: assert property (done_o && mvr |-> count_register_o[15:0] == 16'h0 && !flags_o[4] && !flags_o[2] && !flags_o[1])
		else $error("repeat end wrong");
	AST_IRQ_PC: assert property (irq_take_o |-> resume_pc_o == pc_q && mvr)
		else $error("resume pc wrong");
	cover property (irq_take_o);
	cover property (done_o && op_q == `WBM_OP_MOVE_UP_REP);
	cover property (tk && op_i == `WBM_OP_MULTIPLY);
endmodule // wbm_slice_chk
bind wbm_slice wbm_slice_chk #(.MUL_CYCLES(MUL_CYCLES), .FIFO_DEPTH(FIFO_DEPTH)) chk_i (.*);

// ===== tb/wbm_mem_model.sv
// byte memory answering the slice's read and write ports
`timescale 1ns/1ps
module wbm_mem_model (
	input wire clk_sys_i,
	input wire [1:0] dly_i, // extra wait cycles per answer
	input wire rd_req_o,
	input wire [31:0] rd_addr_o,
	input wire rd_long_o,
	output reg rd_ack_i,
	output reg [31:0] rd_data_i,
	input wire wr_req_o,
	input wire [31:0] wr_addr_o,
	input wire [31:0] wr_data_o,
	input wire wr_long_o,
	input wire [31:0] unused_i,
	output reg wr_ack_i
);
	reg [7:0] m [0:1023]; // little endian store
	reg [1:0] rc, wc; // wait counters
	wire [9:0] ra = rd_addr_o[9:0];
	wire [9:0] wa = wr_addr_o[9:0];
	initial {rd_ack_i, wr_ack_i, rd_data_i, rc, wc} = 0;
	always @(posedge clk_sys_i)
	begin
		rd_ack_i <= 1'b0;
		wr_ack_i <= 1'b0;
		rd_data_i <= ~rd_data_i; // data not held once answered
		if (rd_req_o && !rd_ack_i)
		begin
			rc <= (rc == dly_i) ? 2'd0 : rc + 2'd1;
			if (rc == dly_i)
			begin
				rd_ack_i <= 1'b1;
				rd_data_i <= {rd_long_o ? {m[ra+3], m[ra+2]} : ~{m[ra+1], m[ra]}, m[ra+1], m[ra]};
			end
		end
		if (wr_req_o && !wr_ack_i)
		begin
			wc <= (wc == dly_i) ? 2'd0 : wc + 2'd1;
			if (wc == dly_i)
			begin
				wr_ack_i <= 1'b1;
				{m[wa+1], m[wa]} <= wr_data_o[15:0];
				if (wr_long_o)
					{m[wa+3], m[wa+2]} <= wr_data_o[31:16];
			end
		end
	end
endmodule // wbm_mem_model

// ===== tb/wbm_slice_tb.sv
// self-checking bench for the execution slice
`timescale 1ns/1ps
`include "wbm_defines.vh"
module wbm_slice_tb;
	reg clk_sys_i, nrst_i, start_i, long_word_mode_i, irq_pending_i, or_src_is_index_i, or_byte_sel_i;
	reg [3:0] op_i;
	reg [1:0] dly_i;
	reg [7:0] select_register_i, or_src_i, acc_i, flags_i;
	reg [15:0] src_operand_i, index_register_i, v;
	reg [31:0] instr_pc_i, source_pointer_register_i, destination_pointer_register_i, count_register_i, e;
	reg [31:0] unused_i;
	wire busy_o, done_o, irq_take_o, rd_req_o, rd_long_o, rd_ack_i, wr_req_o, wr_long_o, wr_ack_i;
	wire [7:0] acc_o, flags_o;
	wire [31:0] resume_pc_o, source_pointer_register_o, destination_pointer_register_o;
	wire [31:0] count_register_o, rd_addr_o, rd_data_i, wr_addr_o, wr_data_o;
	integer err_count, tests_run, i, k;
	wbm_slice DUT (.*);
	wbm_mem_model mem (.*);
	initial
	begin
		clk_sys_i = 1'b0;
		forever #50 clk_sys_i = ~clk_sys_i;
	end
	// compare and count
	task chk(input [31:0] seen, input [31:0] exp);
	begin
		tests_run = tests_run + 1;
		if (seen !== exp)
		begin
			err_count = err_count + 1;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	end
	endtask
	task finish_test;
	begin
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	end
	endtask
	task tick;
	begin
		@(posedge clk_sys_i);
		#1;
	end
	endtask
	// one instruction, bounded wait for done or yield
	task go(input [3:0] o);
		integer n;
	begin
		op_i = o;
		start_i = 1'b1;
		tick;
		start_i = 1'b0;
		n = 0;
		while (done_o !== 1'b1 && irq_take_o !== 1'b1 && n < 3000)
		begin
			tick;
			n = n + 1;
		end
		if (n >= 3000)
		begin
			err_count = err_count + 1;
			finish_test;
		end
	end
	endtask
	// pointers and count, kept even by the caller for block moves
	task regs(input [31:0] s, input [31:0] d, input [31:0] c);
	begin
		source_pointer_register_i = s;
		destination_pointer_register_i = d;
		count_register_i = c;
	end
	endtask
	function [7:0] pat(input [31:0] a);
		pat = a[7:0] ^ 8'h5a;
	endfunction
	task cmpmem(input [31:0] s, input [31:0] d, input integer n);
		integer j;
	begin
		for (j = 0; j < n; j = j + 1)
			chk(mem.m[(d + j) & 32'h3ff], pat(s + j));
	end
	endtask
	task ptrs(input [31:0] s, input [31:0] d, input [31:0] c);
	begin
		chk(source_pointer_register_o, s);
		chk(destination_pointer_register_o, d);
		chk(count_register_o, c);
	end
	endtask
	initial
	begin
		{err_count, tests_run, nrst_i, start_i, op_i, long_word_mode_i, irq_pending_i, dly_i} = 0;
		{or_src_is_index_i, or_byte_sel_i, select_register_i, or_src_i, acc_i, flags_i} = 0;
		{src_operand_i, index_register_i, instr_pc_i, unused_i} = 0;
		regs(0, 0, 0);
		for (k = 0; k < 1024; k = k + 1)
			mem.m[k] = pat(k);
		repeat (12) @(posedge clk_sys_i);
		#1;
		nrst_i = 1'b1;
		// byte or: plain zero, index high byte, index low byte
		index_register_i = 16'h8142;
		flags_i = 8'hff;
		for (i = 0; i < 3; i = i + 1)
		begin
			or_src_is_index_i = i != 0;
			or_byte_sel_i = i == 2;
			acc_i = (i == 0) ? 8'h00 : 8'h02;
			e = (i == 0) ? 32'h0 : ((i == 1) ? 32'h83 : 32'h42);
			go(`WBM_OP_OR);
			chk(acc_o, e);
			chk(flags_o & 8'hd7, {e[7], e[7:0] == 8'h0, 3'b000, ~^e[7:0], 2'b00});
		end
		$display("test or done");
		// negate: zero, most negative, small values
		for (i = 0; i < 4; i = i + 1)
		begin
			v = 64'h0000_8000_0001_0010 >> (i * 16);
			regs({16'h1234, v}, 0, 0);
			e = 32'h0 - v;
			go(`WBM_OP_NEGATE);
			chk(source_pointer_register_o, {16'h1234, e[15:0]});
			chk(flags_o & 8'hd7, {e[15], e[15:0] == 16'h0, 1'b0, v[3:0] != 4'h0, 1'b0, v == 16'h8000, 1'b1, v != 16'h0});
		end
		$display("test negate done");
		// multiply, product either side of 65536
		for (i = 0; i < 4; i = i + 1)
		begin
			v = 64'hffff_0000_0100_00ff >> (i * 16);
			src_operand_i = 64'hffff_1234_0100_0101 >> (i * 16);
			regs({16'hbeef, v}, 0, 0);
			e = {16'h0, v} * {16'h0, src_operand_i};
			go(`WBM_OP_MULTIPLY);
			chk(source_pointer_register_o, e);
			chk(flags_o & 8'hc5, {1'b0, e == 32'h0, 5'b0, e >= 32'h10000});
		end
		$display("test multiply done");
		// mode bits to flags
		for (i = 0; i < 2; i = i + 1)
		begin
			select_register_i = (i == 0) ? 8'h82 : 8'h40;
			flags_i = (i == 0) ? 8'h00 : 8'hff;
			go(`WBM_OP_MODE_TEST);
			chk(flags_o & 8'hc1, {select_register_i[7:6], 5'b0, select_register_i[1]});
		end
		$display("test mode done");
		// single moves: short upward, long downward
		flags_i = 8'hc1;
		regs(32'h100, 32'h200, 32'h0003_0004);
		go(`WBM_OP_MOVE_UP);
		ptrs(32'h102, 32'h202, 32'h0003_0002);
		cmpmem(32'h100, 32'h200, 2);
		chk(flags_o & 8'hd7, 8'hc5);
		flags_i = 8'h12;
		long_word_mode_i = 1'b1;
		regs(32'h120, 32'h220, 32'h4);
		go(`WBM_OP_MOVE_DOWN);
		ptrs(32'h11c, 32'h21c, 32'h0);
		cmpmem(32'h120, 32'h220, 4);
		chk(flags_o & 8'hd7, 8'h00);
		$display("test single move done");
		// repeat upward, overlapping with source higher, slow memory
		long_word_mode_i = 1'b0;
		dly_i = 2'd2;
		flags_i = 8'h16;
		regs(32'h304, 32'h300, 32'h8);
		go(`WBM_OP_MOVE_UP_REP);
		ptrs(32'h30c, 32'h308, 32'h0);
		cmpmem(32'h304, 32'h300, 8);
		chk(flags_o & 8'hd7, 8'h00);
		$display("test repeat up done");
		// repeat downward, yields to interrupt, then resumes
		dly_i = 2'd1;
		instr_pc_i = 32'h0000_1230;
		irq_pending_i = 1'b1;
		regs(32'h404, 32'h406, 32'h6);
		go(`WBM_OP_MOVE_DOWN_REP);
		chk(irq_take_o, 1'b1);
		chk(resume_pc_o, 32'h0000_1230);
		ptrs(32'h402, 32'h404, 32'h4);
		irq_pending_i = 1'b0;
		regs(source_pointer_register_o, destination_pointer_register_o, count_register_o);
		go(`WBM_OP_MOVE_DOWN_REP);
		ptrs(32'h3fe, 32'h400, 32'h0);
		cmpmem(32'h400, 32'h402, 6);
		$display("test repeat down done");
		finish_test;
	end
endmodule // wbm_slice_tb
